// file: hw/fwfs_top.sv
`timescale 1ns/100ps
`include "fwfs_regs.svh"
module fwfs_top
  import fwfs_pkg::*;
#(
  parameter int          SECTOR_SHIFT = 15,
  parameter logic [31:0] FLASH_WORDS  = 32'h0010_0000
) (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // flash engine pins
  output logic             flashReq,
  output logic      [4:0]  flashOp,
  output logic      [31:0] flashAddr,
  output logic      [15:0] flashWdata,
  input  wire logic [15:0] flashRdata,
  input  wire logic        flashDone,
  input  wire logic        flashFail
);

  fwfs_regs_s q;
  fwfs_regs_s n;

  function automatic logic [31:0] sectorOf(input logic [31:0] word);
    sectorOf = word >> SECTOR_SHIFT;
  endfunction : sectorOf

  function automatic logic [31:0] sectorBase(input logic [31:0] sector);
    sectorBase = sector << SECTOR_SHIFT;
  endfunction : sectorBase

  logic        acc;
  logic        push;
  logic        pop;
  logic        isCmd;
  logic [31:0] endWord;

  always_comb
  begin
    n       = q;
    push    = 1'b0;
    pop     = 1'b0;
    endWord = 32'h0;
    acc     = psel & penable & ~q.pready;
    isCmd   = acc & pwrite & (paddr == `FWFS_OFF_CMD);
    // pin synchronisers
    n.doneMeta = flashDone;
    n.doneSync = q.doneMeta;
    n.failMeta = flashFail;
    n.failSync = q.failMeta;
    n.rdMeta   = flashRdata;
    n.rdSync   = q.rdMeta;
    n.pready   = 1'b0;
    n.pslverr  = 1'b0;

    // register decode
    if (acc)
    begin
      if (pwrite && paddr == `FWFS_OFF_DATA)
      begin
        if (q.count != (`FWFS_PTR_W+1)'(`FWFS_DEPTH))
        begin
          push     = 1'b1;
          n.prdata = {16'h0, q.fault};
          n.pready = 1'b1;
        end
      end
      else if (isCmd)
      begin
        if (pwdata[2:0] == `FWFS_CMD_CLEAR)
        begin
          n.fault  = `FWFS_FAULT_RESET;
          n.prdata = 32'h0;
          n.pready = 1'b1;
        end
        else if (pwdata[2:0] != `FWFS_CMD_INIT && pwdata[2:0] != `FWFS_CMD_LOAD &&
                 pwdata[2:0] != `FWFS_CMD_PREP)
        begin
          n.pslverr = 1'b1;
          n.pready  = 1'b1;
        end
      end
      else if (pwrite && paddr == `FWFS_OFF_ADDR)
      begin
        n.argAddr = pwdata;
        n.pready  = 1'b1;
      end
      else if (pwrite && paddr == `FWFS_OFF_LEN)
      begin
        n.argLen = pwdata;
        n.pready = 1'b1;
      end
      else if (pwrite && paddr == `FWFS_OFF_RADDR)
      begin
        n.readAddr = pwdata;
        n.pready   = 1'b1;
      end
      else if (!pwrite && paddr == `FWFS_OFF_STATUS)
      begin
        n.prdata = {16'h0, q.fault};
        n.pready = 1'b1;
      end
      else if (!pwrite && paddr == `FWFS_OFF_COUNT)
      begin
        n.prdata = {26'h0, q.count};
        n.pready = 1'b1;
      end
      else if (!pwrite && paddr == `FWFS_OFF_POINTER)
      begin
        n.prdata = {q.ptr[30:0], 1'b0};
        n.pready = 1'b1;
      end
      else if (!pwrite && paddr == `FWFS_OFF_SIZE)
      begin
        n.prdata = q.flashSize;
        n.pready = 1'b1;
      end
      else if (!pwrite && paddr == `FWFS_OFF_ADDR)
      begin
        n.prdata = q.argAddr;
        n.pready = 1'b1;
      end
      else if (!pwrite && paddr == `FWFS_OFF_LEN)
      begin
        n.prdata = q.argLen;
        n.pready = 1'b1;
      end
      else if (!pwrite && paddr == `FWFS_OFF_RADDR)
      begin
        n.prdata = q.readAddr;
        n.pready = 1'b1;
      end
      else if (!(!pwrite && paddr == `FWFS_OFF_RDATA))
      begin
        n.pslverr = 1'b1;
        n.pready  = 1'b1;
      end
    end

    // single sequential flash engine
    case (q.state)
      FWFS_IDLE:
      begin
        if (acc && !pwrite && paddr == `FWFS_OFF_RDATA)
        begin
          n.op        = FWFS_OP_READ;
          n.flashAddr = {1'b0, q.readAddr[31:1]};
          n.flashReq  = 1'b1;
          n.state     = FWFS_WAIT;
        end
        else if (q.count != '0)
        begin
          n.op         = FWFS_OP_PROG;
          n.flashAddr  = q.ptr;
          n.flashWdata = q.mem[q.rdPtr];
          n.flashReq   = 1'b1;
          n.state      = FWFS_WAIT;
        end
        else if (isCmd && pwdata[2:0] == `FWFS_CMD_INIT)
        begin
          n.op       = FWFS_OP_RESET;
          n.flashReq = 1'b1;
          n.state    = FWFS_WAIT;
        end
        else if (isCmd && pwdata[2:0] == `FWFS_CMD_LOAD)
        begin
          n.ptr    = {1'b0, q.argAddr[31:1]};
          n.prdata = {16'h0, q.fault};
          n.pready = 1'b1;
        end
        else if (isCmd && pwdata[2:0] == `FWFS_CMD_PREP)
        begin
          endWord     = {1'b0, q.argAddr[31:1]} + q.argLen - 32'h1;
          n.prepStart = {1'b0, q.argAddr[31:1]};
          n.secCur    = sectorOf({1'b0, q.argAddr[31:1]});
          n.secEnd    = sectorOf(endWord);
          n.op        = FWFS_OP_WIPE;
          n.flashAddr = sectorBase(sectorOf({1'b0, q.argAddr[31:1]}));
          n.flashReq  = 1'b1;
          n.state     = FWFS_WAIT;
        end
      end
      FWFS_WAIT:
      begin
        // waits without limit for completion
        if (q.doneSync)
        begin
          n.flashReq = 1'b0;
          n.state    = FWFS_REL;
          case (q.op)
            FWFS_OP_PROG:
            begin
              pop   = 1'b1;
              n.ptr = q.ptr + 32'h1;
              if (q.failSync)
                n.fault[`FWFS_BIT_PROGFLT] = 1'b1;
            end
            FWFS_OP_READ:
            begin
              n.prdata = {16'h0, q.rdSync};
              n.pready = 1'b1;
            end
            FWFS_OP_WIPE:
            begin
              if (q.failSync)
                n.fault[`FWFS_BIT_WIPEFLT] = 1'b1;
            end
            FWFS_OP_PROBE:
            begin
              n.flashSize = q.failSync ? 32'h0 : FLASH_WORDS;
            end
            default:
            begin
            end
          endcase
        end
      end
      FWFS_REL:
      begin
        if (!q.doneSync)
        begin
          n.state = FWFS_IDLE;
          case (q.op)
            FWFS_OP_RESET:
            begin
              n.op       = FWFS_OP_PROBE;
              n.flashReq = 1'b1;
              n.state    = FWFS_WAIT;
            end
            FWFS_OP_PROBE:
            begin
              n.fault  = `FWFS_FAULT_RESET;
              n.prdata = q.flashSize;
              n.pready = 1'b1;
            end
            FWFS_OP_WIPE:
            begin
              if (q.secCur != q.secEnd)
              begin
                n.secCur    = q.secCur + 32'h1;
                n.flashAddr = sectorBase(q.secCur + 32'h1);
                n.flashReq  = 1'b1;
                n.state     = FWFS_WAIT;
              end
              else
              begin
                n.ptr    = q.prepStart;
                n.prdata = {16'h0, q.fault};
                n.pready = 1'b1;
              end
            end
            default:
            begin
            end
          endcase
        end
      end
      default:
      begin
        n.state    = FWFS_IDLE;
        n.flashReq = 1'b0;
      end
    endcase

    // queue bookkeeping
    if (pop)
    begin
      n.rdPtr = q.rdPtr + (`FWFS_PTR_W)'(1);
      if (q.count == (`FWFS_PTR_W+1)'(1))
        n.fault[`FWFS_BIT_BUSY] = 1'b0;
    end
    if (push)
    begin
      n.mem[q.wrPtr]          = pwdata[15:0];
      n.wrPtr                 = q.wrPtr + (`FWFS_PTR_W)'(1);
      n.fault[`FWFS_BIT_BUSY] = 1'b1;
    end
    n.count = q.count + (`FWFS_PTR_W+1)'(push) - (`FWFS_PTR_W+1)'(pop);
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      q       <= '0;
      q.state <= FWFS_IDLE;
      q.op    <= FWFS_OP_RESET;
      q.fault <= `FWFS_FAULT_RESET;
    end
    else
    begin
      q <= n;
    end
  end

  assign prdata     = q.prdata;
  assign pready     = q.pready;
  assign pslverr    = q.pslverr;
  assign flashReq   = q.flashReq;
  assign flashOp    = q.op;
  assign flashAddr  = q.flashAddr;
  assign flashWdata = q.flashWdata;

endmodule : fwfs_top

// file: hw/fwfs_regs.svh
`ifndef FWFS_REGS_SVH
`define FWFS_REGS_SVH
`define FWFS_OFF_CMD      8'h00
`define FWFS_OFF_ADDR     8'h04
`define FWFS_OFF_LEN      8'h08
`define FWFS_OFF_DATA     8'h0c
`define FWFS_OFF_STATUS   8'h10
`define FWFS_OFF_COUNT    8'h14
`define FWFS_OFF_POINTER  8'h18
`define FWFS_OFF_SIZE     8'h1c
`define FWFS_OFF_RADDR    8'h20
`define FWFS_OFF_RDATA    8'h24
`define FWFS_CMD_INIT     3'h1
`define FWFS_CMD_LOAD     3'h2
`define FWFS_CMD_PREP     3'h3
`define FWFS_CMD_CLEAR    3'h4
`define FWFS_BIT_PROGFLT  0
`define FWFS_BIT_BUSY     1
`define FWFS_BIT_WIPEFLT  2
`define FWFS_FAULT_RESET  16'h0000
`define FWFS_DEPTH        32
`define FWFS_PTR_W        5
`define FWFS_PROG_TIME_US 60
`define FWFS_WIPE_TIME_MS 700
`endif

// file: hw/fwfs_pkg.sv
`include "fwfs_regs.svh"
package fwfs_pkg;
  typedef enum logic [2:0] {
    FWFS_IDLE = 3'b001,
    FWFS_WAIT = 3'b010,
    FWFS_REL  = 3'b100
  } fwfs_state_e;

  typedef enum logic [4:0] {
    FWFS_OP_RESET = 5'b00001,
    FWFS_OP_PROBE = 5'b00010,
    FWFS_OP_READ  = 5'b00100,
    FWFS_OP_PROG  = 5'b01000,
    FWFS_OP_WIPE  = 5'b10000
  } fwfs_op_e;

  typedef struct packed {
    fwfs_state_e                        state;
    fwfs_op_e                           op;
    logic [`FWFS_DEPTH-1:0][15:0]       mem;
    logic [`FWFS_PTR_W-1:0]             rdPtr;
    logic [`FWFS_PTR_W-1:0]             wrPtr;
    logic [`FWFS_PTR_W:0]               count;
    logic [31:0]                        ptr;
    logic [15:0]                        fault;
    logic [31:0]                        secCur;
    logic [31:0]                        secEnd;
    logic [31:0]                        prepStart;
    logic [31:0]                        argAddr;
    logic [31:0]                        argLen;
    logic [31:0]                        readAddr;
    logic [31:0]                        flashSize;
    logic                               doneMeta;
    logic                               doneSync;
    logic                               failMeta;
    logic                               failSync;
    logic [15:0]                        rdMeta;
    logic [15:0]                        rdSync;
    logic                               flashReq;
    logic [31:0]                        flashAddr;
    logic [15:0]                        flashWdata;
    logic [31:0]                        prdata;
    logic                               pready;
    logic                               pslverr;
  } fwfs_regs_s;
endpackage : fwfs_pkg

// file: sim/fwfs_top_properties.sv
`timescale 1ns/100ps
module fwfs_top_properties
  import fwfs_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // flash engine
  input wire logic        flashReq,
  input wire logic [4:0]  flashOp,
  input wire logic [31:0] flashAddr,
  input wire logic        flashDone
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_ready_access: assert property (pready |-> psel && penable && $past(penable))
    else $error("pready outside access phase");
  a_op_onehot: assert property (flashReq |-> $onehot(flashOp))
    else $error("flash op not one-hot");
  a_op_stable: assert property (flashReq && $past(flashReq) |-> $stable(flashAddr))
    else $error("flash address moved during request");
  a_req_hold: assert property (flashReq && !flashDone && !$past(flashDone) |=> flashReq)
    else $error("flash request dropped early");
  a_done_drop: assert property (flashReq && flashDone |-> ##[1:4] !flashReq)
    else $error("flash request not dropped");
  a_new_op: assert property ($rose(flashReq) |-> !flashDone)
    else $error("new op while done high");
endmodule : fwfs_top_properties

bind fwfs_top fwfs_top_properties u_props (.*);

// file: sim/fwfs_flash_model.sv
`timescale 1ns/100ps
module fwfs_flash_model #(
  parameter int WORDS = 4096,
  parameter int SHIFT = 4
) (
  // flash pins
  input  wire logic        mclk,
  input  wire logic        flashReq,
  input  wire logic [4:0]  flashOp,
  input  wire logic [31:0] flashAddr,
  input  wire logic [15:0] flashWdata,
  output logic      [15:0] flashRdata = 16'h5a5a,
  output logic             flashDone = 1'b0,
  output logic             flashFail = 1'b0,
  // bench controls
  input  wire logic        present,
  input  wire logic        hang,
  input  wire logic [7:0]  delay
);
  logic [15:0] mem [0:WORDS-1] = '{default: 16'h0000};
  logic [7:0]  cnt = 8'h00;
  logic        ok;
  assign ok = flashAddr < WORDS;
  always @(posedge mclk)
  begin
    if (!flashReq)
    begin
      // released bus no longer shows the last word
      if (flashDone)
        flashRdata <= ~flashRdata;
      flashDone <= 1'b0;
      flashFail <= 1'b0;
      cnt <= 8'h00;
    end
    else if (!flashDone && !(hang && flashOp == 5'h08))
    begin
      cnt <= cnt + 8'h01;
      if (cnt >= delay)
      begin
        flashDone <= 1'b1;
        case (flashOp)
          5'h02: flashFail <= !present;
          5'h04: flashRdata <= ok ? mem[flashAddr] : ~flashAddr[15:0];
          5'h08:
          begin
            flashFail <= !ok || mem[flashAddr] !== 16'hffff;
            if (ok)
              mem[flashAddr] <= flashWdata;
          end
          5'h10:
          begin
            flashFail <= !ok;
            for (int i = 0; i < (1 << SHIFT); i++)
              if (ok)
                mem[(flashAddr >> SHIFT << SHIFT) + i] <= 16'hffff;
          end
          default: flashFail <= 1'b0;
        endcase
      end
    end
  end
endmodule : fwfs_flash_model

// file: sim/fwfs_top_tb.sv
`timescale 1ns/100ps
`include "fwfs_regs.svh"
module fwfs_top_tb;
  import fwfs_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        present = 1'b1, hang = 1'b0, er, got;
  logic        pready, pslverr, flashReq, flashDone, flashFail;
  logic [7:0]  paddr = 8'h00, delay = 8'h14;
  logic [4:0]  flashOp;
  logic [15:0] flashWdata, flashRdata;
  logic [31:0] pwdata = 32'h0, prdata, rd, flashAddr;
  int          errCount = 0, checks = 0;
  fwfs_top #(.SECTOR_SHIFT(4), .FLASH_WORDS(32'h1000)) u_dut (.*);
  fwfs_flash_model u_flash (.*);
  initial
  begin
    forever #4 mclk = ~mclk;
  end
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20000);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask : apb
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errCount++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask : chk
  task rc(input logic [7:0] a, input logic [31:0] e, input string s);
    apb(1'b0, a, 32'h0);
    chk(s, e, rd);
  endtask : rc
  task rw(input logic [31:0] wa, input logic [31:0] e);
    apb(1'b1, `FWFS_OFF_RADDR, wa << 1);
    rc(`FWFS_OFF_RDATA, e, "flash word");
  endtask : rw
  task cmd(input logic [2:0] c);
    apb(1'b1, `FWFS_OFF_CMD, {29'h0, c});
  endtask : cmd
  task idle;
    int n;
    n = 0;
    do
    begin
      apb(1'b0, `FWFS_OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[`FWFS_BIT_BUSY] !== 1'b0 && n < 500);
  endtask : idle
  task t_init;
    rc(`FWFS_OFF_STATUS, 32'h0, "status");
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    present <= 1'b0;
    cmd(`FWFS_CMD_INIT);
    chk("size none", 32'h0, rd);
    present <= 1'b1;
    cmd(`FWFS_CMD_INIT);
    chk("size", 32'h1000, rd);
    $display("init test done");
  endtask : t_init
  task t_prog;
    apb(1'b1, `FWFS_OFF_ADDR, 32'h22);
    apb(1'b1, `FWFS_OFF_LEN, 32'd20);
    cmd(`FWFS_CMD_PREP);
    chk("prep answer", 32'h0, rd);
    rc(`FWFS_OFF_POINTER, 32'h22, "pointer");
    rw(32'hf, 32'h0);
    rw(32'h10, 32'hffff);
    rw(32'h30, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, `FWFS_OFF_DATA, 32'ha5a0 + i);
      chk("answer", i == 0 ? 32'h0 : 32'h2, rd);
    end
    rc(`FWFS_OFF_STATUS, 32'h2, "busy");
    idle;
    rc(`FWFS_OFF_POINTER, 32'h28, "pointer");
    for (int i = 0; i < 3; i++)
      rw(32'h11 + i, 32'ha5a0 + i);
    $display("program test done");
  endtask : t_prog
  task t_fault;
    apb(1'b1, `FWFS_OFF_ADDR, 32'h0);
    cmd(`FWFS_CMD_LOAD);
    apb(1'b1, `FWFS_OFF_DATA, 32'h1);
    idle;
    rw(32'h10, 32'hffff);
    rc(`FWFS_OFF_STATUS, 32'h1, "program fault");
    cmd(`FWFS_CMD_CLEAR);
    rc(`FWFS_OFF_STATUS, 32'h0, "cleared");
    apb(1'b1, `FWFS_OFF_ADDR, 32'h2000);
    apb(1'b1, `FWFS_OFF_LEN, 32'd1);
    cmd(`FWFS_CMD_PREP);
    rc(`FWFS_OFF_STATUS, 32'h4, "wipe fault");
    cmd(`FWFS_CMD_INIT);
    rc(`FWFS_OFF_STATUS, 32'h0, "init clear");
    $display("fault test done");
  endtask : t_fault
  task t_full;
    delay <= 8'h02;
    apb(1'b1, `FWFS_OFF_ADDR, 32'h200);
    apb(1'b1, `FWFS_OFF_LEN, 32'd40);
    cmd(`FWFS_CMD_PREP);
    hang <= 1'b1;
    for (int i = 0; i < 32; i++)
      apb(1'b1, `FWFS_OFF_DATA, i);
    rc(`FWFS_OFF_COUNT, 32'd32, "full count");
    got = 1'b0;
    fork
      begin
        apb(1'b1, `FWFS_OFF_DATA, 32'h77);
        got = 1'b1;
      end
      begin
        repeat (100) @(posedge mclk);
        chk("stalled", 32'h0, {31'h0, got});
        hang <= 1'b0;
      end
    join
    apb(1'b1, `FWFS_OFF_ADDR, 32'h300);
    cmd(`FWFS_CMD_LOAD);
    rc(`FWFS_OFF_COUNT, 32'h0, "drained");
    rc(`FWFS_OFF_POINTER, 32'h300, "loaded");
    rw(32'h120, 32'h77);
    $display("full queue test done");
  endtask : t_full
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    t_init;
    t_prog;
    t_fault;
    t_full;
    report_and_stop;
  end
  initial
  begin
    repeat (30000) @(posedge mclk);
    errCount++;
    report_and_stop;
  end
endmodule : fwfs_top_tb
